//--- src/dcd_conv.v
`timescale 1ns/1ps
`default_nettype none
`include "dcd_regs.vh"
// one channel: timed conversion of the code from the data register
module dcd_conv #(
	parameter CONV_CYC = `DCD_CONV_CYC,
	parameter CNT_W = 11
)(
	input wire ref_clk,
	input wire rst_b,
	input wire [7:0] code_in,
	input wire conv_en,
	output reg [7:0] code_out_r,
	output reg busy_r
);
	reg [CNT_W-1:0] cnt_r; // cycles left in the running conversion
	reg [7:0] last_code_r; // code of the running or last conversion
	reg en_q_r; // conversion enable one cycle ago
	wire start; // new conversion needed
	localparam integer CNT_LOAD_I = CONV_CYC - 1; // full-width reload count
	localparam [CNT_W-1:0] CNT_LOAD = CNT_LOAD_I[CNT_W-1:0]; // cut to the counter on purpose

	// a fresh enable or a changed code starts conversion at once
	assign start = conv_en & (~en_q_r | (code_in != last_code_r));

	// countdown; the result lands when it runs out
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_r <= {CNT_W{1'b0}};
			last_code_r <= `DCD_CODE_RST;
			en_q_r <= 1'b0;
			busy_r <= 1'b0;
			code_out_r <= `DCD_CODE_RST;
		end
		else
		begin
			en_q_r <= conv_en;
			if (!conv_en)
			begin
				// stopped: drop any conversion, result stays put
				busy_r <= 1'b0;
				cnt_r <= {CNT_W{1'b0}};
			end
			else if (start)
			begin
				// restart on every new code
				last_code_r <= code_in;
				busy_r <= 1'b1;
				cnt_r <= CNT_LOAD;
			end
			else if (busy_r)
			begin
				if (cnt_r == {CNT_W{1'b0}})
				begin
					// result held until the next conversion runs out, even after enable drops
					code_out_r <= last_code_r;
					busy_r <= 1'b0;
				end
				else
				begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- src/dcd_regs.vh
`ifndef DCD_REGS_VH
`define DCD_REGS_VH
// register indices; byte address is four times the index
`define DCD_IDX_CODE0 16'hFFDC
`define DCD_IDX_CODE1 16'hFFDD
`define DCD_IDX_CTRL 16'hFFDE
`define DCD_IDX_STBY 16'hFF5C
// reset values
`define DCD_CODE_RST 8'h00
`define DCD_CTRL_RST 8'h1F
`define DCD_STBY_RST 8'hFE
// field positions in the channel control register
`define DCD_CTRL_OE1 7
`define DCD_CTRL_OE0 6
`define DCD_CTRL_JOINT 5
// bits that are fixed at one and ignore writes
`define DCD_CTRL_RO_MASK 8'h1F
`define DCD_STBY_RO_MASK 8'hFE
// field position in the standby control register
`define DCD_STBY_KEEP 0
// code scale: output is code / 256 of the reference
`define DCD_CODE_STEPS 256
// conversion time and clock period
`define DCD_CONV_TIME_NS 10000
`define DCD_CLK_PERIOD_NS 10
// longest time rounds down to whole cycles
`define DCD_CONV_CYC (`DCD_CONV_TIME_NS / `DCD_CLK_PERIOD_NS)
// ahb transfer type and response codes
`define DCD_HTRANS_NONSEQ 2'h2
`define DCD_HTRANS_SEQ 2'h3
`define DCD_HRESP_OKAY 1'h0
`endif

//--- src/dcd_top.v
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dcd_regs.vh"
module dcd_top #(
	parameter CONV_CYC = `DCD_CONV_CYC
)(
	// clock and reset
	input wire ref_clk,
	input wire rst_b,
	// ahb-lite slave side
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// standby levels from system control, same clock
	input wire sw_standby,
	input wire hw_standby,
	// codes and qualifiers toward the analog circuit
	output reg [7:0] ch0_code_r,
	output reg [7:0] ch1_code_r,
	output reg ch0_conv_en_r,
	output reg ch1_conv_en_r,
	output reg analog_out_ch0_oe_r,
	output reg analog_out_ch1_oe_r,
	output reg ch0_busy_r,
	output reg ch1_busy_r
);
	// register select codes
	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_CODE0 = 3'h1;
	localparam [2:0] SEL_CODE1 = 3'h2;
	localparam [2:0] SEL_CTRL = 3'h3;
	localparam [2:0] SEL_STBY = 3'h4;
	// register word indices
	localparam [15:0] IDX_CODE0 = `DCD_IDX_CODE0;
	localparam [15:0] IDX_CODE1 = `DCD_IDX_CODE1;
	localparam [15:0] IDX_CTRL = `DCD_IDX_CTRL;
	localparam [15:0] IDX_STBY = `DCD_IDX_STBY;
	// read-only bits fixed at one
	localparam [7:0] CTRL_RO = `DCD_CTRL_RO_MASK;
	localparam [7:0] STBY_RO = `DCD_STBY_RO_MASK;

	// conversion on for one channel: own enable, or the partner's when joined
	function dcd_conv_on;
		input own_oe;
		input other_oe;
		input joint;
		begin
			// with both enables clear the result is zero, joined or not
			dcd_conv_on = own_oe | (joint & other_oe);
		end
	endfunction

	// word address to register select
	function [2:0] dcd_decode;
		input [31:0] addr;
		reg [29:0] widx;
		begin
			// compare word index against each register index
			widx = addr[31:2];
			if (widx == {14'h0000, IDX_CODE0})
				dcd_decode = SEL_CODE0;
			else if (widx == {14'h0000, IDX_CODE1})
				dcd_decode = SEL_CODE1;
			else if (widx == {14'h0000, IDX_CTRL})
				dcd_decode = SEL_CTRL;
			else if (widx == {14'h0000, IDX_STBY})
				dcd_decode = SEL_STBY;
			else
				dcd_decode = SEL_NONE;
		end
	endfunction

	// register state
	reg [7:0] code0_r; // dac_code_ch0
	reg [7:0] code1_r; // dac_code_ch1
	reg [7:0] ctrl_r; // dac_channel_control
	reg [7:0] stby_r; // dac_standby_control
	reg [7:0] code0_nxt;
	reg [7:0] code1_nxt;
	reg [7:0] ctrl_nxt;
	reg [7:0] stby_nxt;
	// captured address phase
	reg wr_pend_r; // write data phase follows
	reg [2:0] wr_sel_r; // register chosen by that write
	reg sw_stby_q_r; // software standby one cycle ago
	// combinational helpers
	reg [31:0] rd_nxt; // read data for the next data phase
	wire addr_ok; // valid address phase this cycle
	wire [2:0] sel_now; // decoded select of this address phase
	wire sw_entry; // first cycle of software standby
	// decoded control fields
	wire keep; // standby_output_keep
	wire ch0_output_enable;
	wire ch1_output_enable;
	wire joint_conversion_enable;
	// per-channel paths to the conversion units
	wire [1:0] conv_en; // per-channel conversion enable
	wire [15:0] conv_code; // both held results
	wire [1:0] conv_busy; // both conversion busy flags

	// accepted address phase: selected, bus ready, real transfer
	assign addr_ok = hsel & hready & (htrans == `DCD_HTRANS_NONSEQ | htrans == `DCD_HTRANS_SEQ);
	// decoded once per address phase
	assign sel_now = dcd_decode(haddr);
	// keep bit decides the fate of converter registers in software standby
	assign keep = stby_r[`DCD_STBY_KEEP];
	// rising edge of the standby level, both on the same clock
	assign sw_entry = sw_standby & ~sw_stby_q_r;
	// channel enables straight from the control register
	assign ch0_output_enable = ctrl_r[`DCD_CTRL_OE0];
	assign ch1_output_enable = ctrl_r[`DCD_CTRL_OE1];
	assign joint_conversion_enable = ctrl_r[`DCD_CTRL_JOINT];

	// conversion: own enable, or the other one when joined; none if both clear
	// pin drive is not decided here: it follows own enable only
	assign conv_en[0] = dcd_conv_on(ch0_output_enable, ch1_output_enable,
		joint_conversion_enable);
	assign conv_en[1] = dcd_conv_on(ch1_output_enable, ch0_output_enable,
		joint_conversion_enable);

	// next register values: writes, standby clears, reserved bits
	always @*
	begin
		// hold by default
		code0_nxt = code0_r;
		code1_nxt = code1_r;
		ctrl_nxt = ctrl_r;
		stby_nxt = stby_r;
		if (hw_standby)
		begin
			// hardware standby: everything back to reset values
			code0_nxt = `DCD_CODE_RST;
			code1_nxt = `DCD_CODE_RST;
			ctrl_nxt = `DCD_CTRL_RST;
			stby_nxt = `DCD_STBY_RST;
		end
		else if (sw_entry && !keep)
		begin
			// software standby without keep clears the converter, not standby reg
			code0_nxt = `DCD_CODE_RST;
			code1_nxt = `DCD_CODE_RST;
			ctrl_nxt = `DCD_CTRL_RST;
			// standby register itself survives software standby
		end
		else if (wr_pend_r && !sw_standby)
		begin
			// writes refused during standby so retained values stay put
			// write data phase; with keep set standby leaves values alone
			case (wr_sel_r)
				SEL_CODE0: code0_nxt = hwdata[7:0];
				SEL_CODE1: code1_nxt = hwdata[7:0];
				SEL_CTRL: ctrl_nxt = hwdata[7:0] | CTRL_RO;
				SEL_STBY: stby_nxt = hwdata[7:0] | STBY_RO;
				// unmapped: no register changes
				default: code0_nxt = code0_r;
			endcase
		end
	end

	// read mux from next values so a read right after a write sees it
	always @*
	begin
		// unmapped addresses read as zero
		rd_nxt = 32'h00000000;
		case (sel_now)
			SEL_CODE0: rd_nxt = {24'h000000, code0_nxt};
			SEL_CODE1: rd_nxt = {24'h000000, code1_nxt};
			SEL_CTRL: rd_nxt = {24'h000000, ctrl_nxt | CTRL_RO};
			SEL_STBY: rd_nxt = {24'h000000, stby_nxt | STBY_RO};
			default: rd_nxt = 32'h00000000;
		endcase
	end

	// register file
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// chip reset: initial register values
			code0_r <= `DCD_CODE_RST;
			code1_r <= `DCD_CODE_RST;
			ctrl_r <= `DCD_CTRL_RST;
			stby_r <= `DCD_STBY_RST;
			sw_stby_q_r <= 1'b0;
		end
		else
		begin
			code0_r <= code0_nxt;
			code1_r <= code1_nxt;
			ctrl_r <= ctrl_nxt;
			stby_r <= stby_nxt;
			// standby level delayed to find its entry
			sw_stby_q_r <= sw_standby;
		end
	end

	// ahb-lite slave: zero wait states, always okay
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// nothing pending and bus held off in reset
			wr_pend_r <= 1'b0;
			wr_sel_r <= SEL_NONE;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp <= `DCD_HRESP_OKAY;
		end
		else
		begin
			// never waits and never errors
			hreadyout <= 1'b1;
			hresp <= `DCD_HRESP_OKAY;
			if (addr_ok)
			begin
				// address phase taken
				wr_pend_r <= hwrite;
				wr_sel_r <= sel_now;
				// read data loaded now so it stands in the data phase
				if (!hwrite)
					hrdata <= rd_nxt;
			end
			else
			begin
				// idle or busy: nothing pending
				wr_pend_r <= 1'b0;
				wr_sel_r <= SEL_NONE;
			end
		end
	end

	// one conversion unit per channel
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_ch
			// both units share one timing parameter
			dcd_conv #(
				.CONV_CYC(CONV_CYC)
			) u_conv (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				// channel 0 takes code 0, channel 1 takes code 1
				.code_in(gi == 0 ? code0_r : code1_r),
				.conv_en(conv_en[gi]),
				.code_out_r(conv_code[gi*8 +: 8]),
				.busy_r(conv_busy[gi])
			);
		end
	endgenerate

	// qualifiers and codes toward the analog circuit
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// pins released and codes cleared
			ch0_code_r <= `DCD_CODE_RST;
			ch1_code_r <= `DCD_CODE_RST;
			ch0_conv_en_r <= 1'b0;
			ch1_conv_en_r <= 1'b0;
			analog_out_ch0_oe_r <= 1'b0;
			analog_out_ch1_oe_r <= 1'b0;
			ch0_busy_r <= 1'b0;
			ch1_busy_r <= 1'b0;
		end
		else
		begin
			// held result, value = code / 256 of reference
			ch0_code_r <= conv_code[7:0];
			ch1_code_r <= conv_code[15:8];
			// enables registered, pins move a cycle after the control write
			ch0_conv_en_r <= conv_en[0];
			ch1_conv_en_r <= conv_en[1];
			// pin direction follows own enable only
			analog_out_ch0_oe_r <= ch0_output_enable;
			analog_out_ch1_oe_r <= ch1_output_enable;
			// busy flags show conversions in flight
			ch0_busy_r <= conv_busy[0];
			ch1_busy_r <= conv_busy[1];
		end
	end
endmodule
`default_nettype wire

//--- test/dcd_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcd_regs.vh"
module dual_channel_dac_control_bench;
	localparam logic [31:0] A0 = 4*`DCD_IDX_CODE0; // code 0
	localparam logic [31:0] A1 = 4*`DCD_IDX_CODE1; // code 1
	localparam logic [31:0] AC = 4*`DCD_IDX_CTRL; // control
	localparam logic [31:0] AS = 4*`DCD_IDX_STBY; // standby
	logic ref_clk = 1'h0, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic sw_standby = 1'h0, hw_standby = 1'h0, hreadyout, hresp;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [7:0] ch0_code_r, ch1_code_r;
	logic ch0_conv_en_r, ch1_conv_en_r, ch0_busy_r, ch1_busy_r;
	logic analog_out_ch0_oe_r, analog_out_ch1_oe_r;
	int num_errors = 0, num_checks = 0, cyc = 0;
	dcd_top #(.CONV_CYC(4)) DUT (.ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.sw_standby, .hw_standby, .ch0_code_r, .ch1_code_r, .ch0_conv_en_r,
		.ch1_conv_en_r, .analog_out_ch0_oe_r, .analog_out_ch1_oe_r, .ch0_busy_r, .ch1_busy_r);
	// clock
	initial forever #5 ref_clk = ~ref_clk;
	// verdict and end of run
	task complete_run;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			complete_run;
		end
	end
	// compare seen with expected
	task ck(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		if (s !== e)
			num_errors++;
	endtask
	// one single bus transfer, address then data phase
	task xf(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge ref_clk);
		while (!hreadyout) @(posedge ref_clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
		while (!hreadyout) @(posedge ref_clk);
		q = hrdata;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xf(1'h1, a, d, q);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		xf(1'h0, a, 32'h0, q);
		ck(q, e);
		ck(hresp, 32'h0);
	endtask
	// let registered outputs settle
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// wait bounded for both held codes, then compare
	task wq(input logic [7:0] e0, input logic [7:0] e1);
		for (int i = 0; i < 40 && {ch0_code_r, ch1_code_r} !== {e0, e1}; i++) wt(1);
		ck(ch0_code_r, e0);
		ck(ch1_code_r, e1);
	endtask
	task t_reset;
		rd(A0, 32'h0);
		rd(A1, 32'h0);
		rd(AC, 32'h1F);
		rd(AS, 32'hFE);
		rd(32'h100, 32'h0);
		$display("reset values done");
	endtask
	task t_rsvd;
		wr(AC, 32'h0);
		rd(AC, 32'h1F);
		wr(AS, 32'h0);
		rd(AS, 32'hFE);
		wr(AS, 32'hFF);
		rd(AS, 32'hFF);
		$display("spare bits done");
	endtask
	task t_conv;
		wr(A0, 32'hA5);
		wr(AC, 32'h40);
		wt(3);
		ck(analog_out_ch0_oe_r, 1'h1);
		ck(ch1_conv_en_r, 1'h0);
		wq(8'hA5, 8'h0);
		wr(A0, 32'h3C);
		wt(2);
		ck(ch0_busy_r, 1'h1);
		ck(ch0_code_r, 8'hA5);
		wq(8'h3C, 8'h0);
		wr(AC, 32'h60);
		wt(3);
		ck(ch1_conv_en_r, 1'h1);
		ck(analog_out_ch1_oe_r, 1'h0);
		wr(A1, 32'h77);
		wt(2);
		ck(ch1_busy_r, 1'h1);
		ck(ch1_code_r, 8'h0);
		wq(8'h3C, 8'h77);
		wr(AC, 32'h20);
		wt(8);
		ck({ch0_conv_en_r, ch1_conv_en_r, analog_out_ch0_oe_r}, 3'h0);
		ck(ch0_code_r, 8'h3C);
		$display("conversion done");
	endtask
	task t_stby;
		wr(AC, 32'hC0);
		sw_standby <= 1'h1;
		wr(A0, 32'h11);
		rd(A0, 32'h3C);
		rd(AS, 32'hFF);
		ck(analog_out_ch0_oe_r, 1'h1);
		sw_standby <= 1'h0;
		wr(AS, 32'h0);
		sw_standby <= 1'h1;
		repeat (3) @(posedge ref_clk);
		sw_standby <= 1'h0;
		rd(A0, 32'h0);
		rd(AC, 32'h1F);
		wr(AS, 32'h1);
		wr(AC, 32'hC0);
		hw_standby <= 1'h1;
		repeat (4) @(posedge ref_clk);
		hw_standby <= 1'h0;
		rd(AS, 32'hFE);
		rd(AC, 32'h1F);
		ck(analog_out_ch1_oe_r, 1'h0);
		$display("standby done");
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'h1;
		t_reset;
		t_rsvd;
		t_conv;
		t_stby;
		complete_run;
	end
endmodule
`default_nettype wire

//--- test/dcd_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcd_regs.vh"
// watches bus answers and channel qualifiers of the converter top
module dcd_checker #(
	parameter CONV_CYC = `DCD_CONV_CYC
)(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hw_standby,
	input wire logic ch0_conv_en_r,
	input wire logic ch1_conv_en_r,
	input wire logic analog_out_ch0_oe_r,
	input wire logic analog_out_ch1_oe_r,
	input wire logic ch0_busy_r
);
	localparam logic [31:0] A_CTRL = 4*`DCD_IDX_CTRL; // control byte address
	localparam logic [31:0] A_STBY = 4*`DCD_IDX_STBY; // standby byte address
	logic [15:0] busy_len_r; // length of the running conversion
	logic rd_take; // read address phase accepted
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// count cycles while channel 0 converts
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			busy_len_r <= 16'h0;
		else
			busy_len_r <= ch0_busy_r ? busy_len_r + 16'h1 : 16'h0;
	a_zero_wait: assert property ($past(rst_b) |-> hreadyout)
		else $error("wait state inserted");
	a_ctrl_ones: assert property (rd_take && haddr == A_CTRL |=> hrdata[4:0] == 5'h1F)
		else $error("control spare bits not one");
	a_stby_ones: assert property (rd_take && haddr == A_STBY |=> hrdata[7:1] == 7'h7F)
		else $error("standby spare bits not one");
	a_no_conv: assert property (!analog_out_ch0_oe_r && !analog_out_ch1_oe_r |->
		!ch0_conv_en_r && !ch1_conv_en_r) else $error("conversion without enable");
	a_own_ch0: assert property (analog_out_ch0_oe_r |-> ch0_conv_en_r)
		else $error("channel 0 drives without converting");
	a_own_ch1: assert property (analog_out_ch1_oe_r |-> ch1_conv_en_r)
		else $error("channel 1 drives without converting");
	a_joint_only: assert property (ch1_conv_en_r && !analog_out_ch1_oe_r |->
		analog_out_ch0_oe_r) else $error("channel 1 converts with no enable");
	a_hw_clear: assert property (hw_standby [*3] |->
		!analog_out_ch0_oe_r && !analog_out_ch1_oe_r) else $error("standby left pins on");
	a_busy_bound: assert property (busy_len_r <= CONV_CYC + 3)
		else $error("conversion overran");
	c_ctrl_read: cover property (rd_take && haddr == A_CTRL);
	c_joint: cover property (ch1_conv_en_r && !analog_out_ch1_oe_r);
	c_done: cover property ($fell(ch0_busy_r));
endmodule
bind dcd_top dcd_checker #(.CONV_CYC(CONV_CYC)) u_chk (.ref_clk, .rst_b, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hrdata, .hreadyout, .hw_standby, .ch0_conv_en_r,
	.ch1_conv_en_r, .analog_out_ch0_oe_r, .analog_out_ch1_oe_r, .ch0_busy_r);
`default_nettype wire
